// [logic/agc_pkg.sv]
// Package: register map, field codes and test words of the global config register bank
package agc_pkg;

  // ************************************************
  // Register byte addresses
  // ************************************************
  localparam logic [7:0] ADDR_DIVIDER  = 8'h72;
  localparam logic [7:0] ADDR_DRV_CODE = 8'h73;
  localparam logic [7:0] ADDR_TIMING   = 8'h74;
  localparam logic [7:0] ADDR_CHECK    = 8'h75;
  localparam logic [7:0] ADDR_TEST     = 8'hc0;
  localparam logic [7:0] ADDR_P1_LO    = 8'hc2;
  localparam logic [7:0] ADDR_P1_HI    = 8'hc3;
  localparam logic [7:0] ADDR_P2_LO    = 8'hc4;
  localparam logic [7:0] ADDR_P2_HI    = 8'hc5;

  // ************************************************
  // Reset values and field positions
  // ************************************************
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         DRV_LSB       = 4;
  localparam int         CODE_LSB      = 0;
  localparam int         DLL_BIT       = 3;
  localparam int         DDR_BIT       = 1;
  localparam int         PMODE_LSB     = 4;
  localparam int         TMODE_LSB     = 0;

  // ************************************************
  // Field codes
  // ************************************************
  localparam logic [2:0] SEL_PIN       = 3'h0;
  localparam logic [2:0] DIV_BY1       = 3'h1;
  localparam logic [2:0] DIV_BY2       = 3'h2;
  localparam logic [2:0] DIV_BY4       = 3'h4;
  localparam logic [2:0] DRV_DIFF_2MA  = 3'h1;
  localparam logic [2:0] DRV_DIFF_3MA  = 3'h2;
  localparam logic [2:0] DRV_CMOS      = 3'h4;
  localparam logic [2:0] CODE_TWOS     = 3'h1;
  localparam logic [2:0] CODE_GRAY     = 3'h2;
  localparam logic [2:0] CODE_OFFSET   = 3'h4;

  typedef enum logic [3:0] {
    TST_NORMAL  = 4'h0,
    TST_MID     = 4'h1,
    TST_POS_FS  = 4'h2,
    TST_NEG_FS  = 4'h3,
    TST_CHECKER = 4'h4,
    TST_TOGGLE  = 4'h7,
    TST_USER    = 4'h8
  } agc_test_t;

  localparam logic [1:0] PAT_SINGLE    = 2'h0;
  localparam logic [1:0] PAT_ALTERNATE = 2'h1;

  // ************************************************
  // Test words
  // ************************************************
  localparam logic [15:0] WORD_MID     = 16'h8000;
  localparam logic [15:0] WORD_POS_FS  = 16'hffff;
  localparam logic [15:0] WORD_NEG_FS  = 16'h0000;
  localparam logic [15:0] WORD_CHK_A   = 16'haaaa;
  localparam logic [15:0] WORD_CHK_B   = 16'h5555;
  localparam logic [15:0] WORD_ONES    = 16'hffff;
  localparam logic [15:0] WORD_ZEROS   = 16'h0000;

  // Effective settings handed to the converter core
  typedef struct packed {
    logic [2:0] divider;
    logic [2:0] driver;
    logic [2:0] coding;
    logic       dll_slow;
    logic       ddr_en;
  } agc_cfg_t;

endpackage : agc_pkg

// [logic/agc_regs.sv]
// Global configuration and test pattern register bank with pin fallback
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Divider field: 000 pin control, 001 divide by one, 010 divide by two, 100 divide by four, others reserved.
// - Driver field: 000 pin control, 001 differential 2 mA, 010 differential 3 mA, 100 single-ended CMOS.
// - Coding field: 000 pin control, 001 two's complement, 010 Gray code, 100 offset binary.
// - Divider and both output option registers reset to 00h and keep their contents through a soft reset.
// - One timing bit picks the fast loop range when clear and the slow range when set.
// - The double-rate enable bit reads 0 after power-up on the large package and 1 on the small one.
// - A four-bit test field picks normal, midscale, plus full scale, minus full scale, checkerboard, word toggle or user data.
// - A two-bit field picks single or alternating use of the two user patterns.
// - Each 16-bit user pattern lives in a low byte and a high byte register, all reset to 00h.
// - On the small package the three select pins are absent and the registers still set every function except CMOS output and single-rate output.
// - On the small package pin control means divide by one, 3 mA differential double rate and two's complement.
// - The small package runs differential double-rate output only.
module agc_regs
  import agc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              sys_clk,             // 40 MHz clock
  input  wire logic              nrst,                // Asynchronous reset, active low
  input  wire logic              soft_rst,            // Soft reset pulse, config is kept
  input  wire logic              pkg_small,           // Strap: 1 on the reduced package
  input  wire logic [2:0]        divider_select_pin,  // Decoded divider pin code
  input  wire logic [2:0]        driver_select_pin,   // Decoded driver pin code
  input  wire logic [2:0]        coding_select_pin,   // Decoded coding pin code
  input  wire logic              reg_wr,              // Register write strobe
  input  wire logic              reg_rd,              // Register read strobe
  input  wire logic [7:0]        reg_addr,            // Register address
  input  wire logic [7:0]        reg_wdata,           // Write data
  output logic      [7:0]        reg_rdata,           // Read data, registered
  input  wire logic              sample_tick,         // One pulse per output word
  input  wire logic [DATA_W-1:0] adc_data,            // Normal converter data
  output logic      [DATA_W-1:0] out_word,            // Output word, registered
  output agc_cfg_t               cfg                  // Effective settings, registered
);

  // Test words and the pattern byte pairs are fixed at sixteen bits
  if (DATA_W != 16) begin : g_width_check
    $error("agc_regs: DATA_W must be 16");
  end

  // ************************************************
  // Storage
  // ************************************************
  logic [7:0]  divider_r;
  logic [7:0]  drv_code_r;
  logic [7:0]  timing_r;
  logic [7:0]  test_r;
  logic [15:0] pat1_r;
  logic [15:0] pat2_r;
  logic        strap_done_r;
  logic        small_r;
  logic        alt_sel_r;
  logic        phase_r;
  agc_cfg_t    cfg_nxt;
  logic [7:0]  rdata_nxt;
  logic [15:0] word_nxt;
  logic [2:0]  div_f;
  logic [2:0]  drv_f;
  logic [2:0]  code_f;
  logic [2:0]  div_eff;
  logic [2:0]  drv_eff;
  logic [2:0]  code_eff;
  logic        alt_mode;

  assign div_f  = divider_r[2:0];
  assign drv_f  = drv_code_r[DRV_LSB +: 3];
  assign code_f = drv_code_r[CODE_LSB +: 3];
  assign alt_mode = (test_r[PMODE_LSB +: 2] == PAT_ALTERNATE);

  // Only nrst clears the config; soft_rst is deliberately not a term here
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      divider_r  <= REG_RESET;
      drv_code_r <= REG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_DIVIDER) begin
        divider_r <= reg_wdata;
      end
      if (reg_addr == ADDR_DRV_CODE) begin
        drv_code_r <= reg_wdata;
      end
    end
  end

  // ************************************************
  // Package strap capture
  // ************************************************
  // The strap is caught on the first edge after release, never under reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_done_r <= 1'b0;
      small_r      <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      small_r      <= pkg_small;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timing_r <= REG_RESET;
    end else if (reg_wr && reg_addr == ADDR_TIMING) begin
      timing_r <= reg_wdata;
    end else if (!strap_done_r) begin
      timing_r[DDR_BIT] <= pkg_small;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      test_r <= REG_RESET;
      pat1_r <= {2{REG_RESET}};
      pat2_r <= {2{REG_RESET}};
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_TEST:  test_r       <= reg_wdata;
        ADDR_P1_LO: pat1_r[7:0]  <= reg_wdata;
        ADDR_P1_HI: pat1_r[15:8] <= reg_wdata;
        ADDR_P2_LO: pat2_r[7:0]  <= reg_wdata;
        ADDR_P2_HI: pat2_r[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ************************************************
  // Effective configuration
  // ************************************************
  // A nonzero field always beats the pins, so the small package loses no divider setting
  always_comb begin
    if (div_f != SEL_PIN) begin
      div_eff = div_f;
    end else if (small_r) begin
      div_eff = DIV_BY1;
    end else begin
      div_eff = divider_select_pin;
    end
  end

  // The small package has no single-ended drivers, so CMOS falls back to 3 mA
  always_comb begin
    if (drv_f == SEL_PIN) begin
      drv_eff = small_r ? DRV_DIFF_3MA : driver_select_pin;
    end else if (small_r && drv_f == DRV_CMOS) begin
      drv_eff = DRV_DIFF_3MA;
    end else begin
      drv_eff = drv_f;
    end
  end

  always_comb begin
    if (code_f != SEL_PIN) begin
      code_eff = code_f;
    end else if (small_r) begin
      code_eff = CODE_TWOS;
    end else begin
      code_eff = coding_select_pin;
    end
  end

  // Reserved nonzero codes pass through untouched; the host is trusted to avoid them
  always_comb begin
    cfg_nxt.divider  = div_eff;
    cfg_nxt.driver   = drv_eff;
    cfg_nxt.coding   = code_eff;
    cfg_nxt.dll_slow = timing_r[DLL_BIT];
    // The stored bit still reads back as written; only the effective setting is forced
    cfg_nxt.ddr_en   = timing_r[DDR_BIT] | small_r;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cfg <= '0;
    end else begin
      cfg <= cfg_nxt;
    end
  end

  // ************************************************
  // Register read port
  // ************************************************
  always_comb begin
    case (reg_addr)
      ADDR_DIVIDER:  rdata_nxt = divider_r;
      ADDR_DRV_CODE: rdata_nxt = drv_code_r;
      ADDR_TIMING:   rdata_nxt = timing_r;
      // Parity over the three config bytes lets the host check its writes
      ADDR_CHECK:    rdata_nxt = {7'h00, ^{divider_r, drv_code_r, timing_r}};
      ADDR_TEST:     rdata_nxt = test_r;
      ADDR_P1_LO:    rdata_nxt = pat1_r[7:0];
      ADDR_P1_HI:    rdata_nxt = pat1_r[15:8];
      ADDR_P2_LO:    rdata_nxt = pat2_r[7:0];
      ADDR_P2_HI:    rdata_nxt = pat2_r[15:8];
      default:       rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ************************************************
  // Test pattern generator
  // ************************************************
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r   <= 1'b0;
      alt_sel_r <= 1'b0;
    end else if (soft_rst) begin
      phase_r   <= 1'b0;
      alt_sel_r <= 1'b0;
    end else if (sample_tick) begin
      phase_r <= ~phase_r;
      if (alt_mode) begin
        alt_sel_r <= ~alt_sel_r;
      end else begin
        alt_sel_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (test_r[TMODE_LSB +: 4])
      TST_NORMAL:  word_nxt = adc_data;
      TST_MID:     word_nxt = WORD_MID;
      TST_POS_FS:  word_nxt = WORD_POS_FS;
      TST_NEG_FS:  word_nxt = WORD_NEG_FS;
      TST_CHECKER: word_nxt = phase_r ? WORD_CHK_B : WORD_CHK_A;
      TST_TOGGLE:  word_nxt = phase_r ? WORD_ZEROS : WORD_ONES;
      // Leaving alternate mode must not strand the output on the second pattern
      TST_USER:    word_nxt = (alt_mode && alt_sel_r) ? pat2_r : pat1_r;
      default:     word_nxt = adc_data;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_word <= '0;
    end else if (sample_tick) begin
      out_word <= word_nxt;
    end
  end

endmodule : agc_regs

`default_nettype wire

// [testbench/agc_host.sv]
// Host model that drives the register port
`timescale 1ns/100ps
`default_nettype none
module agc_host (
  input  wire logic       sys_clk,   // Clock
  output logic            reg_wr,    // Write strobe
  output logic            reg_rd,    // Read strobe
  output logic      [7:0] reg_addr,  // Address
  output logic      [7:0] reg_wdata, // Write data
  input  wire logic [7:0] reg_rdata  // Read data
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Callers hand in defined field codes only; idle lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : agc_host
`default_nettype wire

// [testbench/agc_regs_chk.sv]
// Port-level assertions for the config register bank
`timescale 1ns/100ps
`default_nettype none
module agc_regs_chk
  import agc_pkg::*;
#(parameter int DATA_W = 16) (
  input wire logic              sys_clk,     // Clock
  input wire logic              nrst,        // Reset
  input wire logic              pkg_small,   // Strap
  input wire logic              reg_wr,      // Write
  input wire logic              reg_rd,      // Read
  input wire logic [7:0]        reg_addr,    // Address
  input wire logic [7:0]        reg_wdata,   // Write data
  input wire logic [7:0]        reg_rdata,   // Read data
  input wire logic              sample_tick, // Tick
  input wire logic [DATA_W-1:0] out_word,    // Output
  input wire agc_cfg_t          cfg          // Settings
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_div;
    reg_wr && reg_addr == ADDR_DIVIDER && reg_wdata[2:0] != SEL_PIN ##1 !reg_wr
      |=> cfg.divider == $past(reg_wdata[2:0], 2);
  endproperty
  a_div: assert property (p_div) else $error("divider setting not applied");
  property p_drv;
    !pkg_small && reg_wr && reg_addr == ADDR_DRV_CODE && reg_wdata[6:4] != SEL_PIN ##1 !reg_wr
      |=> cfg.driver == $past(reg_wdata[6:4], 2);
  endproperty
  a_drv: assert property (p_drv) else $error("driver setting not applied");
  property p_dll;
    reg_wr && reg_addr == ADDR_TIMING ##1 !reg_wr |=> cfg.dll_slow == $past(reg_wdata[DLL_BIT], 2);
  endproperty
  a_dll: assert property (p_dll) else $error("loop range not applied");
  property p_ddr;
    pkg_small && $past(nrst, 2) |-> cfg.ddr_en;
  endproperty
  a_ddr: assert property (p_ddr) else $error("double rate off on small package");
  property p_unm;
    reg_rd && reg_addr inside {8'h76, 8'hc1, 8'hff} |=> reg_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_rdst;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdst: assert property (p_rdst) else $error("read data moved without read");
  property p_outst;
    !sample_tick && !$past(sample_tick) |=> $stable(out_word);
  endproperty
  a_outst: assert property (p_outst) else $error("output word moved without tick");
  property p_mid;
    reg_wr && reg_addr == ADDR_TEST && reg_wdata == 8'h01 ##1 !reg_wr ##1 sample_tick |=> out_word == WORD_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("midscale word wrong");
  c_test: cover property (reg_wr && reg_addr == ADDR_TEST);
  c_small: cover property (pkg_small && sample_tick);
  c_check: cover property (reg_rd && reg_addr == ADDR_CHECK);
endmodule : agc_regs_chk
bind agc_regs agc_regs_chk #(.DATA_W(DATA_W)) u_chk (.sys_clk(sys_clk), .nrst(nrst), .pkg_small(pkg_small),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .sample_tick(sample_tick), .out_word(out_word), .cfg(cfg));
`default_nettype wire

// [testbench/agc_regs_bench.sv]
// Self-checking bench for the config register bank
`timescale 1ns/100ps
`default_nettype none
module agc_regs_bench;
  import agc_pkg::*;
  typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } agc_row_t;
  // Check register follows the rows above it: parity of 04, 41 and 0a is 1
  agc_row_t rows [11] = '{'{8'h72, 8'h04, 8'h04}, '{8'h73, 8'h41, 8'h41}, '{8'h74, 8'h0a, 8'h0a},
    '{8'h75, 8'hff, 8'h01}, '{8'hc0, 8'h18, 8'h18}, '{8'hc2, 8'h34, 8'h34}, '{8'hc3, 8'h12, 8'h12},
    '{8'hc4, 8'hcd, 8'hcd}, '{8'hc5, 8'hab, 8'hab}, '{8'hc1, 8'hff, 8'h00}, '{8'h76, 8'hff, 8'h00}};
  logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
  logic [15:0] words [6] = '{16'h5a5a, WORD_MID, WORD_POS_FS, WORD_NEG_FS, WORD_CHK_A, WORD_ONES};
  logic sys_clk, nrst, soft_rst, pkg_small, reg_wr, reg_rd, sample_tick;
  logic [2:0] divider_select_pin, driver_select_pin, coding_select_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
  logic [15:0] adc_data, out_word;
  agc_cfg_t cfg;
  int mismatches = 0;
  int checks_done = 0;
  agc_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .soft_rst(soft_rst), .pkg_small(pkg_small),
    .divider_select_pin(divider_select_pin), .driver_select_pin(driver_select_pin),
    .coding_select_pin(coding_select_pin), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_tick(sample_tick), .adc_data(adc_data),
    .out_word(out_word), .cfg(cfg));
  agc_host u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input string nm, input logic [15:0] e);
    @(posedge sys_clk);
    sample_tick <= 1'b1;
    @(posedge sys_clk);
    sample_tick <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(nm, e, out_word);
  endtask : tick
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // A full run is under two hundred cycles
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    nrst = 1'b0;
    soft_rst = 1'b0;
    pkg_small = 1'b0;
    sample_tick = 1'b0;
    adc_data = 16'h5a5a;
    divider_select_pin = DIV_BY2;
    driver_select_pin = DRV_CMOS;
    coding_select_pin = CODE_GRAY;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      u_host.rd(rows[i].a, rd_v);
      chk("reset value", 16'h0000, {8'h00, rd_v});
    end
    foreach (rows[i]) begin
      u_host.wr(rows[i].a, rows[i].d);
      u_host.rd(rows[i].a, rd_v);
      chk("readback", {8'h00, rows[i].e}, {8'h00, rd_v});
    end
    chk("settings", {5'h00, DIV_BY4, DRV_CMOS, CODE_TWOS, 2'b11}, {5'h00, cfg});
    tick("first pattern", 16'h1234);
    tick("second pattern", 16'habcd);
    foreach (codes[i]) begin
      @(posedge sys_clk);
      soft_rst <= 1'b1;
      @(posedge sys_clk);
      soft_rst <= 1'b0;
      u_host.wr(ADDR_TEST, {4'h0, codes[i]});
      tick("test word", words[i]);
    end
    tick("toggle word", WORD_ZEROS);
    u_host.wr(ADDR_TEST, {4'h0, TST_CHECKER});
    tick("checker first", WORD_CHK_A);
    tick("checker second", WORD_CHK_B);
    // Leave alternate mode right after the first pattern: single use must go back to it
    u_host.wr(ADDR_TEST, {2'b00, PAT_ALTERNATE, TST_USER});
    tick("alternate first", 16'h1234);
    u_host.wr(ADDR_TEST, {2'b00, PAT_SINGLE, TST_USER});
    tick("single use", 16'h1234);
    tick("single use", 16'h1234);
    u_host.rd(ADDR_DIVIDER, rd_v);
    chk("kept by soft reset", 16'h0004, {8'h00, rd_v});
    u_host.wr(ADDR_DIVIDER, 8'h00);
    u_host.wr(ADDR_DRV_CODE, 8'h00);
    @(posedge sys_clk);
    #1;
    chk("pin control", {7'h00, DIV_BY2, DRV_CMOS, CODE_GRAY}, {7'h00, cfg[10:2]});
    u_host.wr(ADDR_DIVIDER, {5'h00, DIV_BY1});
    u_host.wr(ADDR_DRV_CODE, {1'b0, DRV_DIFF_2MA, 1'b0, CODE_OFFSET});
    @(posedge sys_clk);
    #1;
    chk("codes a", {7'h00, DIV_BY1, DRV_DIFF_2MA, CODE_OFFSET}, {7'h00, cfg[10:2]});
    u_host.wr(ADDR_DRV_CODE, {1'b0, DRV_DIFF_3MA, 1'b0, CODE_GRAY});
    @(posedge sys_clk);
    #1;
    chk("codes b", {10'h000, DRV_DIFF_3MA, CODE_GRAY}, {10'h000, cfg.driver, cfg.coding});
    @(posedge sys_clk);
    nrst <= 1'b0;
    pkg_small <= 1'b1;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    u_host.rd(ADDR_TIMING, rd_v);
    chk("small timing", 16'h0002, {8'h00, rd_v});
    chk("small defaults", {5'h00, DIV_BY1, DRV_DIFF_3MA, CODE_TWOS, 2'b01}, {5'h00, cfg});
    u_host.wr(ADDR_DRV_CODE, 8'h40);
    u_host.wr(ADDR_DIVIDER, 8'h04);
    @(posedge sys_clk);
    #1;
    chk("small override", {10'h000, DIV_BY4, DRV_DIFF_3MA}, {10'h000, cfg.divider, cfg.driver});
    wrap_up();
  end
endmodule : agc_regs_bench
`default_nettype wire
